//--- pll_enable_and_flexio_config.v
// Three configuration registers: PLL enables and wake-up, flexible pin muxing, pad rail and holdover mapping.
// Also holds the PLL notification sticky bits and their masks that feed the pin mux.
// Assumes a byte-wide register port decoded upstream and notification inputs already on SYS_CLK.
//
// Notes on behaviour
// - bit 7 picks second manual wake-up control
// - bit 6 low selects manual wake-up sequence
// - supply code bits 5:4, 00/01/10 voltages
// - bits 3:0 enable PLLs A-D, low active
// - flex register bit 7 sets pin one direction
// - pin one selector bits 6:4, 000 zero
// - code 001 drives OR of all notifications
// - code 010 drives OR of PLL notifications
// - 011 input monitor OR, 100 live status
// - flex register bit 3 sets pin two direction
// - pin two selector bits 2:0, same codes
// - spare bit 7 fixes pad rail selection
// - spare bit 6 maps per-PLL forced holdover
// - PLL notifications sticky, mask zero suppresses
`timescale 1ns/10ps
`default_nettype none
`include "pll_flex_cfg_map.vh"

module pll_enable_and_flexio_config (
   // Clock and reset
   input wire SYS_CLK,
   input wire SYS_RST,
   // Register port
   input wire REG_WR,
   input wire REG_RD,
   input wire [7:0] REG_ADDR,
   input wire [7:0] REG_WDATA,
   output reg [7:0] REG_RDATA,
   // Wake-up and supply controls
   input wire MANUAL_WAKEUP_FIRST_N,
   input wire MANUAL_WAKEUP_SECOND_N,
   output reg MANUAL_WAKEUP_N,
   output reg MANUAL_WAKEUP_SEQ,
   output reg [1:0] DEFAULT_SUPPLY_CODE,
   output reg [3:0] PLL_EN_N,
   // Pad rail and holdover
   output reg PAD_RAIL_FIXED,
   output reg HOLDOVER_MAP_EN,
   // Notification sources
   input wire [3:0] PLL_LOSS_OF_LOCK,
   input wire [3:0] HOLDOVER_FREEZE_FLAG,
   input wire CLKMON_NOTIFY_ANY,
   input wire CLKMON_LIVE_STATUS,
   input wire [2:0] DEBUG_SIG,
   // Flexible pins
   input wire FLEX_PIN_ONE_IN,
   output reg FLEX_PIN_ONE_OUT,
   output reg FLEX_PIN_ONE_OE,
   input wire FLEX_PIN_TWO_IN,
   output reg FLEX_PIN_TWO_OUT,
   output reg FLEX_PIN_TWO_OE
);

   reg [7:0] pll_enable_wakeup_cfg_reg;
   reg [7:0] flex_pin_dir_mux_cfg_reg;
   reg [7:0] pad_rail_holdover_cfg_reg;
   reg [7:0] notify_mask_reg;
   reg [7:0] notify_sticky_reg;
   reg [7:0] notify_sticky_next;
   reg [7:0] pll_events_prev_reg;
   reg [1:0] pin_one_sync_reg;
   reg [1:0] pin_two_sync_reg;
   wire [7:0] pll_events;
   wire [7:0] pll_rise;
   wire pll_notify_any;
   wire all_notify_any;
   reg one_next;
   reg two_next;

   ////////////////////////////////////////////////////////////////////////////
   // Register writes and readback
   always @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         pll_enable_wakeup_cfg_reg <= `PLL_ENABLE_WAKEUP_CFG_RST;
         flex_pin_dir_mux_cfg_reg <= `FLEX_PIN_DIR_MUX_CFG_RST;
         pad_rail_holdover_cfg_reg <= `PAD_RAIL_HOLDOVER_CFG_RST;
         notify_mask_reg <= `NOTIFY_MASK_RST;
         REG_RDATA <= 8'h00;
      end else begin
         if (REG_WR) begin
            case (REG_ADDR)
               `PLL_ENABLE_WAKEUP_CFG_OFS: pll_enable_wakeup_cfg_reg <= REG_WDATA;
               `FLEX_PIN_DIR_MUX_CFG_OFS: flex_pin_dir_mux_cfg_reg <= REG_WDATA;
               `PAD_RAIL_HOLDOVER_CFG_OFS: pad_rail_holdover_cfg_reg <= REG_WDATA;
               `NOTIFY_MASK_OFS: notify_mask_reg <= REG_WDATA;
               default: ;
            endcase
         end
         if (REG_RD) begin
            case (REG_ADDR)
               `PLL_ENABLE_WAKEUP_CFG_OFS: REG_RDATA <= pll_enable_wakeup_cfg_reg;
               `FLEX_PIN_DIR_MUX_CFG_OFS: REG_RDATA <= flex_pin_dir_mux_cfg_reg;
               `PAD_RAIL_HOLDOVER_CFG_OFS: REG_RDATA <= pad_rail_holdover_cfg_reg;
               `NOTIFY_MASK_OFS: REG_RDATA <= notify_mask_reg;
               `NOTIFY_STICKY_OFS: REG_RDATA <= notify_sticky_reg;
               default: REG_RDATA <= 8'h00;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // PLL notification sticky bits, set on a rising event, cleared by writing 1
   assign pll_events = {HOLDOVER_FREEZE_FLAG, PLL_LOSS_OF_LOCK};
   assign pll_rise = pll_events & ~pll_events_prev_reg;

   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1) begin : g_sticky
         // Set beats clear so an event in the clearing cycle survives
         always @* begin
            notify_sticky_next[i] = notify_sticky_reg[i];
            if (REG_WR && REG_ADDR == `NOTIFY_STICKY_OFS && REG_WDATA[i])
               notify_sticky_next[i] = 1'b0;
            if (pll_rise[i] && notify_mask_reg[i])
               notify_sticky_next[i] = 1'b1;
         end
      end
   endgenerate

   always @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         notify_sticky_reg <= `NOTIFY_STICKY_RST;
         pll_events_prev_reg <= 8'h00;
      end else begin
         notify_sticky_reg <= notify_sticky_next;
         pll_events_prev_reg <= pll_events;
      end
   end

   assign pll_notify_any = |notify_sticky_reg;
   assign all_notify_any = pll_notify_any | CLKMON_NOTIFY_ANY;

   ////////////////////////////////////////////////////////////////////////////
   // Pin input synchronisers; pin one's sampled level is routed back to pin two's debug mux code 7
   always @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         pin_one_sync_reg <= 2'h0;
         pin_two_sync_reg <= 2'h0;
      end else begin
         pin_one_sync_reg <= {pin_one_sync_reg[0], FLEX_PIN_ONE_IN};
         pin_two_sync_reg <= {pin_two_sync_reg[0], FLEX_PIN_TWO_IN};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Flexible pin muxes
   function mux_pick;
      input [2:0] sel;
      input all_n, pll_n, mon_n, live;
      input [2:0] dbg;
      begin
         case (sel)
            `FSEL_ZERO: mux_pick = 1'b0;
            `FSEL_ALL_NOTIFY: mux_pick = all_n;
            `FSEL_PLL_NOTIFY: mux_pick = pll_n;
            `FSEL_CLKMON_NOTIFY: mux_pick = mon_n;
            `FSEL_CLKMON_LIVE: mux_pick = live;
            3'h5: mux_pick = dbg[0];
            3'h6: mux_pick = dbg[1];
            default: mux_pick = dbg[2];
         endcase
      end
   endfunction

   always @* begin
      one_next = 1'b0;
      two_next = 1'b0;
      if (flex_pin_dir_mux_cfg_reg[`FLEX_ONE_DIR_BIT])
         one_next = mux_pick(flex_pin_dir_mux_cfg_reg[`FLEX_ONE_SEL_MSB:`FLEX_ONE_SEL_LSB],
            all_notify_any, pll_notify_any, CLKMON_NOTIFY_ANY, CLKMON_LIVE_STATUS, DEBUG_SIG);
      if (flex_pin_dir_mux_cfg_reg[`FLEX_TWO_DIR_BIT])
         two_next = mux_pick(flex_pin_dir_mux_cfg_reg[`FLEX_TWO_SEL_MSB:`FLEX_TWO_SEL_LSB],
            all_notify_any, pll_notify_any, CLKMON_NOTIFY_ANY, CLKMON_LIVE_STATUS,
            {pin_one_sync_reg[1], DEBUG_SIG[1:0]});
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered control outputs
   always @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         MANUAL_WAKEUP_N <= 1'b1;
         MANUAL_WAKEUP_SEQ <= 1'b1;
         DEFAULT_SUPPLY_CODE <= `SUPPLY_1V8;
         PLL_EN_N <= 4'h0;
         PAD_RAIL_FIXED <= 1'b0;
         HOLDOVER_MAP_EN <= 1'b0;
         FLEX_PIN_ONE_OUT <= 1'b0;
         FLEX_PIN_ONE_OE <= 1'b0;
         FLEX_PIN_TWO_OUT <= 1'b0;
         FLEX_PIN_TWO_OE <= 1'b0;
      end else begin
         MANUAL_WAKEUP_N <= pll_enable_wakeup_cfg_reg[`WAKEUP_SEL_BIT] ?
            MANUAL_WAKEUP_SECOND_N : MANUAL_WAKEUP_FIRST_N;
         MANUAL_WAKEUP_SEQ <= ~pll_enable_wakeup_cfg_reg[`WAKEUP_MANUAL_N_BIT];
         DEFAULT_SUPPLY_CODE <= pll_enable_wakeup_cfg_reg[`SUPPLY_MSB:`SUPPLY_LSB];
         PLL_EN_N <= pll_enable_wakeup_cfg_reg[`PLL_EN_N_MSB:`PLL_EN_N_LSB];
         PAD_RAIL_FIXED <= pad_rail_holdover_cfg_reg[`RAIL_FIXED_BIT];
         HOLDOVER_MAP_EN <= pad_rail_holdover_cfg_reg[`HOLDOVER_MAP_BIT];
         FLEX_PIN_ONE_OUT <= one_next;
         FLEX_PIN_ONE_OE <= flex_pin_dir_mux_cfg_reg[`FLEX_ONE_DIR_BIT];
         FLEX_PIN_TWO_OUT <= two_next;
         FLEX_PIN_TWO_OE <= flex_pin_dir_mux_cfg_reg[`FLEX_TWO_DIR_BIT];
      end
   end

endmodule // pll_enable_and_flexio_config
`default_nettype wire

//--- pll_flex_cfg_map.vh
// Register offsets, field positions and reset values of the PLL enable and flexible pin configuration slice.
// Included by the register bank; holds definitions only.
`ifndef PLL_FLEX_CFG_MAP_VH
`define PLL_FLEX_CFG_MAP_VH

// Register offsets on the configuration port
`define PLL_ENABLE_WAKEUP_CFG_OFS 8'h10
`define FLEX_PIN_DIR_MUX_CFG_OFS 8'h18
`define PAD_RAIL_HOLDOVER_CFG_OFS 8'h19
`define NOTIFY_MASK_OFS 8'h08
`define NOTIFY_STICKY_OFS 8'h07

// Reset values
`define PLL_ENABLE_WAKEUP_CFG_RST 8'h00
`define FLEX_PIN_DIR_MUX_CFG_RST 8'h00
`define PAD_RAIL_HOLDOVER_CFG_RST 8'h00
`define NOTIFY_MASK_RST 8'hff
`define NOTIFY_STICKY_RST 8'h00

// Fields of the PLL enable register
`define WAKEUP_SEL_BIT 7
`define WAKEUP_MANUAL_N_BIT 6
`define SUPPLY_MSB 5
`define SUPPLY_LSB 4
`define PLL_EN_N_MSB 3
`define PLL_EN_N_LSB 0

// Supply encodings
`define SUPPLY_1V8 2'h0
`define SUPPLY_2V5 2'h1
`define SUPPLY_3V3 2'h2

// Fields of the flexible pin register
`define FLEX_ONE_DIR_BIT 7
`define FLEX_ONE_SEL_MSB 6
`define FLEX_ONE_SEL_LSB 4
`define FLEX_TWO_DIR_BIT 3
`define FLEX_TWO_SEL_MSB 2
`define FLEX_TWO_SEL_LSB 0

// Flexible pin selector codes
`define FSEL_ZERO 3'h0
`define FSEL_ALL_NOTIFY 3'h1
`define FSEL_PLL_NOTIFY 3'h2
`define FSEL_CLKMON_NOTIFY 3'h3
`define FSEL_CLKMON_LIVE 3'h4

// Fields of the pad rail and holdover register
`define RAIL_FIXED_BIT 7
`define HOLDOVER_MAP_BIT 6

`endif

//--- pll_cfg_monitor.sv
// Checker for the PLL enable and flexible pin configuration slice.
// Sees only top-level ports; bound from the testbench top file.
`timescale 1ns/10ps
`default_nettype none
module pll_cfg_monitor (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   // Register writes
   input wire logic REG_WR,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   // Controls
   input wire logic MANUAL_WAKEUP_SEQ,
   input wire logic [1:0] DEFAULT_SUPPLY_CODE,
   input wire logic [3:0] PLL_EN_N,
   input wire logic PAD_RAIL_FIXED,
   input wire logic HOLDOVER_MAP_EN,
   // Flexible pins
   input wire logic FLEX_PIN_ONE_OUT,
   input wire logic FLEX_PIN_ONE_OE,
   input wire logic FLEX_PIN_TWO_OUT,
   input wire logic FLEX_PIN_TWO_OE
);
   ////////////////////////////////////////////////////////////////
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (SYS_RST);
   // Register loads at the write edge, outputs follow one edge later
   wire w_pll = REG_WR && (REG_ADDR == 8'h10);
   wire w_flex = REG_WR && (REG_ADDR == 8'h18);
   wire w_rail = REG_WR && (REG_ADDR == 8'h19);
   ////////////////////////////////////////////////////////////////
   property p_pll_en; w_pll |-> ##2 PLL_EN_N == $past(REG_WDATA[3:0], 2); endproperty
   a_pll_en: assert property (p_pll_en) else $error("PLL enables not loaded");
   property p_supply; w_pll |-> ##2 DEFAULT_SUPPLY_CODE == $past(REG_WDATA[5:4], 2); endproperty
   a_supply: assert property (p_supply) else $error("Supply code not loaded");
   property p_seq; w_pll |-> ##2 MANUAL_WAKEUP_SEQ == !$past(REG_WDATA[6], 2); endproperty
   a_seq: assert property (p_seq) else $error("Wake-up sequence wrong");
   property p_dir_one; w_flex |-> ##2 FLEX_PIN_ONE_OE == $past(REG_WDATA[7], 2); endproperty
   a_dir_one: assert property (p_dir_one) else $error("Pin one direction wrong");
   property p_dir_two; w_flex |-> ##2 FLEX_PIN_TWO_OE == $past(REG_WDATA[3], 2); endproperty
   a_dir_two: assert property (p_dir_two) else $error("Pin two direction wrong");
   property p_rail; w_rail |-> ##2 {PAD_RAIL_FIXED, HOLDOVER_MAP_EN} == $past(REG_WDATA[7:6], 2); endproperty
   a_rail: assert property (p_rail) else $error("Rail or holdover bit wrong");
   property p_quiet_one; !FLEX_PIN_ONE_OE |-> !FLEX_PIN_ONE_OUT; endproperty
   a_quiet_one: assert property (p_quiet_one) else $error("Input pin one driven");
   property p_quiet_two; !FLEX_PIN_TWO_OE |-> !FLEX_PIN_TWO_OUT; endproperty
   a_quiet_two: assert property (p_quiet_two) else $error("Input pin two driven");
endmodule // pll_cfg_monitor
`default_nettype wire

//--- tb.sv
// Self-checking bench for the PLL enable and flexible pin configuration slice.
// Drives every input at the falling edge; the checker is bound at the foot.
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   logic wk1_n = 1'b1, wk2_n = 1'b0, wk_n, seq, rail, hmap, mon = 1'b0, live = 1'b0;
   logic p1i = 1'b0, p2i = 1'b0, p1o, p1e, p2o, p2e;
   logic [1:0] sup;
   logic [3:0] en_n, lol = 4'h0, frz = 4'h0;
   logic [2:0] dbg = 3'h5;
   int err_count = 0, compares = 0;
   always #50 clk = ~clk;
   pll_enable_and_flexio_config pll_enable_and_flexio_config_inst (.SYS_CLK(clk), .SYS_RST(rst),
      .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
      .MANUAL_WAKEUP_FIRST_N(wk1_n), .MANUAL_WAKEUP_SECOND_N(wk2_n), .MANUAL_WAKEUP_N(wk_n),
      .MANUAL_WAKEUP_SEQ(seq), .DEFAULT_SUPPLY_CODE(sup), .PLL_EN_N(en_n), .PAD_RAIL_FIXED(rail),
      .HOLDOVER_MAP_EN(hmap), .PLL_LOSS_OF_LOCK(lol), .HOLDOVER_FREEZE_FLAG(frz), .CLKMON_NOTIFY_ANY(mon),
      .CLKMON_LIVE_STATUS(live), .DEBUG_SIG(dbg), .FLEX_PIN_ONE_IN(p1i), .FLEX_PIN_ONE_OUT(p1o),
      .FLEX_PIN_ONE_OE(p1e), .FLEX_PIN_TWO_IN(p2i), .FLEX_PIN_TWO_OUT(p2o), .FLEX_PIN_TWO_OE(p2e));
   ////////////////////////////////////////////////////////////////
   task cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Two spare cycles let the registered outputs follow the write
   task bw(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      cyc(2);
   endtask
   task br(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk);
      addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      chk("rdata", rdata, exp);
   endtask
   ////////////////////////////////////////////////////////////////
   task t_reset;
      br(8'h10, 8'h00);
      br(8'h18, 8'h00);
      br(8'h19, 8'h00);
      br(8'h33, 8'h00);
      chk("ctl", {seq, wk_n, rail, hmap, en_n}, 8'hc0);
   endtask
   task t_pll;
      bw(8'h10, 8'hd5);
      br(8'h10, 8'hd5);
      chk("pll", {seq, wk_n, sup, en_n}, 8'h15);
      bw(8'h10, 8'h2a);
      chk("pll", {seq, wk_n, sup, en_n}, 8'hea);
      wk1_n = 1'b0;
      cyc(2);
      chk("wake", {7'h0, wk_n}, 8'h00);
   endtask
   task scan(input logic any, input logic lv, input logic stk);
      int c;
      logic e;
      mon = any;
      live = lv;
      p1i = lv;
      for (c = 0; c < 8; c++) begin
         bw(8'h18, {1'b1, c[2:0], 1'b1, c[2:0]});
         e = (c == 1 && (any || stk)) || (c == 2 && stk) || (c == 3 && any) || (c == 4 && lv);
         chk("oe", {6'h0, p1e, p2e}, 8'h03);
         if (c < 5) chk("out", {6'h0, p1o, p2o}, {6'h0, e, e});
         else chk("dbg", {6'h0, p1o, p2o}, {6'h0, dbg[c - 5], (c == 7) ? p1i : dbg[c - 5]});
      end
   endtask
   task t_flex;
      scan(1'b1, 1'b0, 1'b0);
      scan(1'b0, 1'b1, 1'b0);
      lol = 4'h4;
      cyc(4);
      br(8'h07, 8'h04);
      scan(1'b0, 1'b0, 1'b1);
      bw(8'h18, 8'h77);
      chk("in", {p1e, p1o, p2e, p2o}, 8'h00);
      bw(8'h08, 8'h00);
      bw(8'h07, 8'hff);
      frz = 4'h1;
      cyc(4);
      br(8'h07, 8'h00);
      // A new event in the clearing cycle must survive the clear
      bw(8'h08, 8'hff);
      @(negedge clk);
      addr = 8'h07;
      wdata = 8'hff;
      reg_wr = 1'b1;
      frz = 4'h3;
      @(negedge clk);
      reg_wr = 1'b0;
      br(8'h07, 8'h20);
   endtask
   task t_rail;
      bw(8'h19, 8'hc0);
      chk("rail", {rail, hmap}, 8'h03);
      br(8'h19, 8'hc0);
      bw(8'h19, 8'h40);
      chk("rail", {rail, hmap}, 8'h01);
   endtask
   task conclude;
      if (err_count == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      cyc(3);
      rst = 1'b0;
      t_reset;
      t_pll;
      t_flex;
      t_rail;
      conclude;
   end
   // Whole sequence needs well under a thousand cycles
   initial begin
      #2000000;
      err_count++;
      conclude;
   end
endmodule // tb
bind pll_enable_and_flexio_config pll_cfg_monitor pll_cfg_monitor_inst (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
   .REG_WR(REG_WR), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .MANUAL_WAKEUP_SEQ(MANUAL_WAKEUP_SEQ),
   .DEFAULT_SUPPLY_CODE(DEFAULT_SUPPLY_CODE), .PLL_EN_N(PLL_EN_N), .PAD_RAIL_FIXED(PAD_RAIL_FIXED),
   .HOLDOVER_MAP_EN(HOLDOVER_MAP_EN), .FLEX_PIN_ONE_OUT(FLEX_PIN_ONE_OUT), .FLEX_PIN_ONE_OE(FLEX_PIN_ONE_OE),
   .FLEX_PIN_TWO_OUT(FLEX_PIN_TWO_OUT), .FLEX_PIN_TWO_OE(FLEX_PIN_TWO_OE));
`default_nettype wire
